// ### rtl/port_status_event_registers.sv
// status, attachment-type and write-one-to-clear event registers
`timescale 1ns/1ns
`default_nettype none
// one write-one-to-clear event flag bit
module event_flag_cell (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // set pulse and clear request
  input wire logic set_evt,
  input wire logic clr_req,
  // flag value after the next edge and now
  output logic flag_nxt,
  output logic flag_r
);

  // a new event wins over a clear in the same cycle
  assign flag_nxt = set_evt || (flag_r && !clr_req);

  // sticky flag, masks never stop it setting
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule

module port_status_event_registers
  import port_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port from the serial interface logic
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // mask settings held elsewhere in the device
  input wire logic [7:0] event_mask,
  input wire logic [7:0] stabilize_event_mask,
  input wire logic global_irq_mask,
  // detection status, same clock
  input wire logic weak_battery_sink_on,
  input wire logic bus_power_discharged,
  input wire logic [1:0] plug_side,
  input wire logic bus_power_valid,
  input wire logic [1:0] advertised_current_level,
  input wire logic attached,
  input wire logic sink_cc_fault,
  input wire logic stabilizing,
  input wire logic debug_acc_provider,
  input wire logic debug_acc_consumer,
  input wire logic attached_sink,
  input wire logic attached_source,
  input wire logic powered_cable_seen,
  input wire logic headset_acc_with_bus_power,
  input wire logic headset_acc,
  // detection events, one-cycle pulses
  input wire logic cc_over_rd_evt,
  input wire logic bus_power_cross_evt,
  input wire logic stabilization_power_off_evt,
  input wire logic stabilization_power_on_evt,
  input wire logic stabilization_start_evt,
  input wire logic stabilization_fail_evt,
  input wire logic forced_role_ok_evt,
  input wire logic forced_role_fail_evt,
  // interrupt toward the host, active low
  output logic irq_n
);

  logic [7:0] attach_status_r;
  logic [7:0] fault_stabilize_status_r;
  logic [7:0] attach_kind_r;
  logic [7:0] event_flags_r;
  logic [7:0] event_flags_nxt;
  logic [7:0] stabilize_event_flags_r;
  logic [7:0] stabilize_event_flags_nxt;
  logic [7:0] ev_set;
  logic [7:0] se_set;
  logic [7:0] ev_clr;
  logic [7:0] se_clr;
  logic [7:0] rd_sel;
  logic ev_pending;
  logic se_pending;

  // attach status snapshot, registered once per clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      attach_status_r <= REG_RESET;
    end else begin
      attach_status_r[ST_WEAK_BATT] <= weak_battery_sink_on;
      attach_status_r[ST_DISCHARGED] <= bus_power_discharged;
      attach_status_r[ST_SIDE_HI:ST_SIDE_LO] <= plug_side;
      attach_status_r[ST_BUS_VALID] <= bus_power_valid;
      attach_status_r[ST_LEVEL_HI:ST_LEVEL_LO] <=
        advertised_current_level;
      attach_status_r[ST_ATTACHED] <= attached;
    end
  end

  // fault and stabilization snapshot; upper bits reserved
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_stabilize_status_r <= REG_RESET;
    end else begin
      fault_stabilize_status_r[7:2] <= 6'h00;
      fault_stabilize_status_r[FS_FAULT] <= sink_cc_fault;
      fault_stabilize_status_r[FS_STABILIZING] <= stabilizing;
    end
  end

  // attachment kind snapshot; top bit reserved
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      attach_kind_r <= REG_RESET;
    end else begin
      attach_kind_r[7] <= 1'b0;
      attach_kind_r[AK_DEBUG_PROVIDER] <= debug_acc_provider;
      attach_kind_r[AK_DEBUG_CONSUMER] <= debug_acc_consumer;
      attach_kind_r[AK_SINK] <= attached_sink;
      attach_kind_r[AK_SOURCE] <= attached_source;
      attach_kind_r[AK_POWERED_CABLE] <= powered_cable_seen;
      attach_kind_r[AK_HEADSET_BUS] <= headset_acc_with_bus_power;
      attach_kind_r[AK_HEADSET] <= headset_acc;
    end
  end

  // event detection from registered status versus new inputs; fault and bus power change pass their event pulses straight through
  always_comb begin
    ev_set = REG_RESET;
    ev_set[EV_SIDE] = (attach_status_r[ST_SIDE_HI:ST_SIDE_LO] == SIDE_NONE)
      && (plug_side == SIDE_CC1 || plug_side == SIDE_CC2);
    ev_set[EV_FAULT] = cc_over_rd_evt;
    ev_set[EV_BUS_CHG] = bus_power_cross_evt;
    ev_set[EV_WEAK_BATT] =
      attach_status_r[ST_WEAK_BATT] != weak_battery_sink_on;
    ev_set[EV_LEVEL] = attach_status_r[ST_LEVEL_HI:ST_LEVEL_LO] !=
      advertised_current_level;
    ev_set[EV_UNPLUG] = attach_status_r[ST_ATTACHED] && !attached;
    ev_set[EV_ATTACH] = !attach_status_r[ST_ATTACHED] && attached;
  end

  // stabilization and forced-role events
  always_comb begin
    se_set = REG_RESET;
    se_set[SE_POWER_OFF] = stabilization_power_off_evt;
    se_set[SE_POWER_ON] = stabilization_power_on_evt;
    se_set[SE_FAIL] = stabilization_fail_evt;
    se_set[SE_STABILIZE] = stabilization_start_evt;
    se_set[SE_FORCE_OK] = forced_role_ok_evt;
    se_set[SE_FORCE_FAIL] = forced_role_fail_evt;
  end

  // write-one-to-clear decode
  always_comb begin
    ev_clr = REG_RESET;
    se_clr = REG_RESET;
    if (reg_wr && reg_addr == ADDR_EVENT_FLAGS) begin
      ev_clr = reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_STABILIZE_EVENT_FLAGS) begin
      se_clr = reg_wdata;
    end
  end

  // reserved flag bits never set
  assign event_flags_nxt[7] = 1'b0;
  assign event_flags_r[7] = 1'b0;
  assign stabilize_event_flags_nxt[7] = 1'b0;
  assign stabilize_event_flags_r[7] = 1'b0;
  assign stabilize_event_flags_nxt[4] = 1'b0;
  assign stabilize_event_flags_r[4] = 1'b0;

  // event_flags bits, one cell each

  // plug side flag
  event_flag_cell i_side_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(ev_set[EV_SIDE]),
    .clr_req(ev_clr[EV_SIDE]),
    .flag_nxt(event_flags_nxt[EV_SIDE]),
    .flag_r(event_flags_r[EV_SIDE])
  );

  // CC fault flag
  event_flag_cell i_fault_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(ev_set[EV_FAULT]),
    .clr_req(ev_clr[EV_FAULT]),
    .flag_nxt(event_flags_nxt[EV_FAULT]),
    .flag_r(event_flags_r[EV_FAULT])
  );

  // bus power change flag
  event_flag_cell i_bus_chg_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(ev_set[EV_BUS_CHG]),
    .clr_req(ev_clr[EV_BUS_CHG]),
    .flag_nxt(event_flags_nxt[EV_BUS_CHG]),
    .flag_r(event_flags_r[EV_BUS_CHG])
  );

  // weak battery sink flag
  event_flag_cell i_weak_batt_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(ev_set[EV_WEAK_BATT]),
    .clr_req(ev_clr[EV_WEAK_BATT]),
    .flag_nxt(event_flags_nxt[EV_WEAK_BATT]),
    .flag_r(event_flags_r[EV_WEAK_BATT])
  );

  // current level flag
  event_flag_cell i_level_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(ev_set[EV_LEVEL]),
    .clr_req(ev_clr[EV_LEVEL]),
    .flag_nxt(event_flags_nxt[EV_LEVEL]),
    .flag_r(event_flags_r[EV_LEVEL])
  );

  // unplug flag
  event_flag_cell i_unplug_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(ev_set[EV_UNPLUG]),
    .clr_req(ev_clr[EV_UNPLUG]),
    .flag_nxt(event_flags_nxt[EV_UNPLUG]),
    .flag_r(event_flags_r[EV_UNPLUG])
  );

  // attach flag
  event_flag_cell i_attach_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(ev_set[EV_ATTACH]),
    .clr_req(ev_clr[EV_ATTACH]),
    .flag_nxt(event_flags_nxt[EV_ATTACH]),
    .flag_r(event_flags_r[EV_ATTACH])
  );

  // stabilize_event_flags bits, one cell each

  // power off request flag
  event_flag_cell i_power_off_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(se_set[SE_POWER_OFF]),
    .clr_req(se_clr[SE_POWER_OFF]),
    .flag_nxt(stabilize_event_flags_nxt[SE_POWER_OFF]),
    .flag_r(stabilize_event_flags_r[SE_POWER_OFF])
  );

  // power on request flag
  event_flag_cell i_power_on_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(se_set[SE_POWER_ON]),
    .clr_req(se_clr[SE_POWER_ON]),
    .flag_nxt(stabilize_event_flags_nxt[SE_POWER_ON]),
    .flag_r(stabilize_event_flags_r[SE_POWER_ON])
  );

  // stabilization failure flag
  event_flag_cell i_fail_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(se_set[SE_FAIL]),
    .clr_req(se_clr[SE_FAIL]),
    .flag_nxt(stabilize_event_flags_nxt[SE_FAIL]),
    .flag_r(stabilize_event_flags_r[SE_FAIL])
  );

  // forced role failure flag
  event_flag_cell i_force_fail_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(se_set[SE_FORCE_FAIL]),
    .clr_req(se_clr[SE_FORCE_FAIL]),
    .flag_nxt(stabilize_event_flags_nxt[SE_FORCE_FAIL]),
    .flag_r(stabilize_event_flags_r[SE_FORCE_FAIL])
  );

  // forced role success flag
  event_flag_cell i_force_ok_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(se_set[SE_FORCE_OK]),
    .clr_req(se_clr[SE_FORCE_OK]),
    .flag_nxt(stabilize_event_flags_nxt[SE_FORCE_OK]),
    .flag_r(stabilize_event_flags_r[SE_FORCE_OK])
  );

  // stabilization start flag
  event_flag_cell i_stabilize_flag (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(se_set[SE_STABILIZE]),
    .clr_req(se_clr[SE_STABILIZE]),
    .flag_nxt(stabilize_event_flags_nxt[SE_STABILIZE]),
    .flag_r(stabilize_event_flags_r[SE_STABILIZE])
  );

  // unmasked flags of the next cycle
  assign ev_pending = |(event_flags_nxt & ~event_mask);
  assign se_pending = |(stabilize_event_flags_nxt & ~stabilize_event_mask);

  // interrupt follows unmasked flags of the next cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= global_irq_mask || !(ev_pending || se_pending);
    end
  end

  // read select; unmapped addresses read zero
  always_comb begin
    rd_sel = REG_RESET;
    case (reg_addr)
      ADDR_ATTACH_STATUS: rd_sel = attach_status_r;
      ADDR_FAULT_STABILIZE_STATUS: rd_sel = fault_stabilize_status_r;
      ADDR_ATTACH_KIND: rd_sel = attach_kind_r;
      ADDR_EVENT_FLAGS: rd_sel = event_flags_r;
      ADDR_STABILIZE_EVENT_FLAGS: rd_sel = stabilize_event_flags_r;
      default: rd_sel = REG_RESET;
    endcase
  end

  // read data, registered; holds until the next read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= REG_RESET;
    end else if (reg_rd) begin
      reg_rdata <= rd_sel;
    end
  end

endmodule
`default_nettype wire

// ### rtl/port_status_pkg.sv
// register map, field positions and encodings of the port status bank
package port_status_pkg;

  // register addresses on the internal register port
  localparam logic [7:0] ADDR_ATTACH_STATUS = 8'h11;
  localparam logic [7:0] ADDR_FAULT_STABILIZE_STATUS = 8'h12;
  localparam logic [7:0] ADDR_ATTACH_KIND = 8'h13;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_STABILIZE_EVENT_FLAGS = 8'h15;
  localparam logic [7:0] REG_RESET = 8'h00;

  // attach_status fields
  localparam int ST_WEAK_BATT = 7;
  localparam int ST_DISCHARGED = 6;
  localparam int ST_SIDE_HI = 5;
  localparam int ST_SIDE_LO = 4;
  localparam int ST_BUS_VALID = 3;
  localparam int ST_LEVEL_HI = 2;
  localparam int ST_LEVEL_LO = 1;
  localparam int ST_ATTACHED = 0;

  // fault_stabilize_status fields
  localparam int FS_FAULT = 1;
  localparam int FS_STABILIZING = 0;

  // attach_kind fields
  localparam int AK_DEBUG_PROVIDER = 6;
  localparam int AK_DEBUG_CONSUMER = 5;
  localparam int AK_SINK = 4;
  localparam int AK_SOURCE = 3;
  localparam int AK_POWERED_CABLE = 2;
  localparam int AK_HEADSET_BUS = 1;
  localparam int AK_HEADSET = 0;

  // event_flags fields
  localparam int EV_SIDE = 6;
  localparam int EV_FAULT = 5;
  localparam int EV_BUS_CHG = 4;
  localparam int EV_WEAK_BATT = 3;
  localparam int EV_LEVEL = 2;
  localparam int EV_UNPLUG = 1;
  localparam int EV_ATTACH = 0;

  // stabilize_event_flags fields
  localparam int SE_POWER_OFF = 6;
  localparam int SE_POWER_ON = 5;
  localparam int SE_FAIL = 3;
  localparam int SE_FORCE_FAIL = 2;
  localparam int SE_FORCE_OK = 1;
  localparam int SE_STABILIZE = 0;

  // implemented bits of each event register (reserved bits stay zero)
  localparam logic [7:0] EV_IMPL_MASK = 8'h7f;
  localparam logic [7:0] SE_IMPL_MASK = 8'h6f;

  // plug side encodings
  localparam logic [1:0] SIDE_NONE = 2'h0;
  localparam logic [1:0] SIDE_CC1 = 2'h1;
  localparam logic [1:0] SIDE_CC2 = 2'h2;
  localparam logic [1:0] SIDE_FAULT = 2'h3;

endpackage

// ### testbench/host_model.sv
// host register access model for the port status bank
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr, reg_rd,
  output logic [7:0] reg_addr, reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0_0000;
  // one strobe cycle, then address and data scrambled
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk) {reg_rd, reg_addr} = {1'b0, ~a};
    @(negedge clk) d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### testbench/port_status_checker.sv
// assertions on the port status bank ports
`timescale 1ns/1ns
`default_nettype none
module port_status_checker (
  // clock, reset, register port
  input wire logic clk, arst_n, reg_rd,
  input wire logic [7:0] reg_addr, reg_rdata,
  // masks, status, events, interrupt
  input wire logic [7:0] event_mask, stabilize_event_mask,
  input wire logic global_irq_mask, attached, sink_cc_fault,
  input wire logic stabilizing, cc_over_rd_evt, stabilization_fail_evt,
  input wire logic irq_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // attach edges against the last sample
  sequence plug_in;
    attached && !$past(attached);
  endsequence
  sequence plug_out;
    !attached && $past(attached);
  endsequence
  stat1_read_a: assert property (
    reg_rd && reg_addr == 8'h12 && $past(arst_n) |=> reg_rdata == {6'h00,
    $past(sink_cc_fault, 2), $past(stabilizing, 2)}) else $error("fault_stabilize_status");
  attach_irq_a: assert property (
    plug_in ##0 (!global_irq_mask && !event_mask[0]) |=> !irq_n)
    else $error("attach irq");
  unplug_irq_a: assert property (
    plug_out ##0 (!global_irq_mask && !event_mask[1] && $past(arst_n))
    |=> !irq_n)
    else $error("unplug irq");
  fault_irq_a: assert property (
    cc_over_rd_evt && !global_irq_mask && !event_mask[5] |=> !irq_n)
    else $error("fault irq");
  stab_fail_a: assert property (
    stabilization_fail_evt && !global_irq_mask && !stabilize_event_mask[3]
    |=> !irq_n) else $error("fail irq");
  global_mask_a: assert property (
    global_irq_mask [*2] |-> irq_n) else $error("global mask");
  full_mask_a: assert property (
    (event_mask == 8'hff && stabilize_event_mask == 8'hff) [*2] |-> irq_n)
    else $error("full mask");
  unmapped_rd_a: assert property (
    reg_rd && !(reg_addr inside {[8'h11:8'h15]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("rdata hold");
endmodule
`default_nettype wire

// ### testbench/port_status_event_registers_tb.sv
// testbench for the port status bank
`timescale 1ns/1ns
`default_nettype none
module port_status_event_registers_tb;
  logic clk, arst_n, gmask, irq_n, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, emask, smask, st, kd, ev, d;
  logic [1:0] s1;
  int fail_count, tests_run;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  host_model i_host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  port_status_event_registers i_dut (.clk(clk), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .event_mask(emask),
    .stabilize_event_mask(smask), .global_irq_mask(gmask),
    .weak_battery_sink_on(st[7]), .bus_power_discharged(st[6]),
    .plug_side(st[5:4]), .bus_power_valid(st[3]),
    .advertised_current_level(st[2:1]), .attached(st[0]),
    .sink_cc_fault(s1[1]), .stabilizing(s1[0]),
    .debug_acc_provider(kd[6]), .debug_acc_consumer(kd[5]),
    .attached_sink(kd[4]), .attached_source(kd[3]),
    .powered_cable_seen(kd[2]), .headset_acc_with_bus_power(kd[1]),
    .headset_acc(kd[0]), .cc_over_rd_evt(ev[7]),
    .bus_power_cross_evt(ev[6]), .stabilization_power_off_evt(ev[5]),
    .stabilization_power_on_evt(ev[4]), .stabilization_start_evt(ev[3]),
    .stabilization_fail_evt(ev[2]), .forced_role_ok_evt(ev[1]),
    .forced_role_fail_evt(ev[0]), .irq_n(irq_n));
  task automatic chk(input string n, input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, e);
    i_host.rd(a, d);
    chk($sformatf("reg_%h", a), d, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic final_report;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    fail_count++;
    final_report;
  end
  initial begin
    {arst_n, gmask, emask, smask, st, s1, kd, ev} = 44'h000_0000_0000;
    tick(6);
    arst_n = 1'b1;
    for (int a = 17; a <= 22; a++) rd_chk(8'(a), 8'h00);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    $display("reset test done");
    // attach on side one at 1.5 A with all kinds, fault and stabilizing set
    {st, s1, kd} = {8'h5d, 2'h3, 8'h7f};
    tick(2);
    chk("irq_n", {7'h00, irq_n}, 8'h00);
    rd_chk(8'h11, 8'h5d);
    rd_chk(8'h12, 8'h03);
    rd_chk(8'h13, 8'h7f);
    rd_chk(8'h14, 8'h45);
    i_host.wr(8'h11, 8'hff);
    rd_chk(8'h11, 8'h5d);
    i_host.wr(8'h14, 8'h05);
    rd_chk(8'h14, 8'h40);
    i_host.wr(8'h14, 8'hff);
    rd_chk(8'h14, 8'h00);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    $display("attach test done");
    // side fault and release, weak battery toggle, detach
    st = 8'h7d;
    tick(2);
    st = 8'h4d;
    tick(2);
    rd_chk(8'h14, 8'h00);
    st = 8'h80;
    tick(2);
    rd_chk(8'h11, 8'h80);
    st = 8'h00;
    tick(2);
    rd_chk(8'h14, 8'h0e);
    i_host.wr(8'h14, 8'hff);
    st = 8'h20;
    tick(2);
    rd_chk(8'h11, 8'h20);
    rd_chk(8'h14, 8'h40);
    st = 8'h00;
    tick(2);
    i_host.wr(8'h14, 8'hff);
    $display("change test done");
    // every pulse event once, then mask combinations
    for (int i = 0; i < 8; i++) begin
      ev = 8'(1 << i);
      tick(1);
      ev = 8'h00;
      tick(1);
    end
    {emask, smask} = 16'hffff;
    tick(2);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    rd_chk(8'h14, 8'h30);
    rd_chk(8'h15, 8'h6f);
    {emask, gmask} = 9'h001;
    tick(2);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    gmask = 1'b0;
    tick(2);
    chk("irq_n", {7'h00, irq_n}, 8'h00);
    i_host.wr(8'h14, 8'hff);
    i_host.wr(8'h15, 8'hff);
    rd_chk(8'h15, 8'h00);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    $display("event test done");
    final_report;
  end
endmodule
bind port_status_event_registers port_status_checker i_chk (.clk(clk),
  .arst_n(arst_n), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .event_mask(event_mask),
  .stabilize_event_mask(stabilize_event_mask),
  .global_irq_mask(global_irq_mask), .attached(attached),
  .sink_cc_fault(sink_cc_fault), .stabilizing(stabilizing),
  .cc_over_rd_evt(cc_over_rd_evt),
  .stabilization_fail_evt(stabilization_fail_evt), .irq_n(irq_n));
`default_nettype wire
